// ### inc/gapm_pkg.sv
`default_nettype none
package gapm_pkg;
  // ----------------------------------------
  // Register map, word addresses
  // ----------------------------------------
  localparam logic [3:0] ADDR_FUNC_SEL = 4'h0;
  localparam logic [3:0] ADDR_GPIO_DIR = 4'h1;
  localparam logic [3:0] ADDR_GPIO_OUT = 4'h2;
  localparam logic [3:0] ADDR_PIN_IN = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  // ----------------------------------------
  // Pin indices of the shared pin vector
  // ----------------------------------------
  localparam int NUM_PINS = 12;
  localparam int PIN_GIO0 = 0;
  localparam int PIN_GIO1 = 1;
  localparam int PIN_GIO2 = 2;
  localparam int PIN_GIO3 = 3;
  localparam int PIN_GIO9 = 4;
  localparam int PIN_FAST2 = 5;
  localparam int PIN_FAST3 = 6;
  localparam int PIN_REG5 = 7;
  localparam int PIN_REG6 = 8;
  localparam int PIN_REG7 = 9;
  localparam int PIN_REG8 = 10;
  localparam int PIN_SPARE = 11;
  // ----------------------------------------
  // Function select fields
  // ----------------------------------------
  localparam int FSEL_SLAVE_AUDIO = 0;
  localparam int FSEL_MASTER_AUDIO = 1;
  localparam int FSEL_FAST_SPI = 2;
  localparam logic [2:0] FUNC_SEL_RST = 3'h0;
  localparam logic [11:0] GPIO_DIR_RST = 12'h000;
  localparam logic [11:0] GPIO_OUT_RST = 12'h000;
  localparam logic [11:0] FAST_PIN_MASK = 12'h060;
  // ----------------------------------------
  // Audio source bundle
  // ----------------------------------------
  typedef struct packed {
    logic slave_word_clock;
    logic slave_bit_clock;
    logic data_a;
    logic data_b;
    logic data_c;
    logic data_d;
    logic master_word_clock;
  } gapm_audio_t;
  typedef struct packed {
    logic [11:0] out;
    logic [11:0] oe;
  } gapm_pins_t;
endpackage
`default_nettype wire

// ### rtl/gapm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module gapm_sync #(
  parameter int WIDTH = 12
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  // Pins are async to the core clock
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end
  assign sync_o = sync_r;
endmodule
`default_nettype wire

// ### rtl/gapm_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module gapm_pin_mux (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic dual_link_i,
  input wire gapm_pkg::gapm_audio_t audio_i,
  input wire logic [11:0] pin_in_i,
  output logic [11:0] pin_out_o,
  output logic [11:0] pin_oe_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [2:0] func_sel_r;
  logic [11:0] gpio_dir_r;
  logic [11:0] gpio_out_r;
  logic [31:0] rdata_r;
  logic [11:0] pin_in_sync;
  logic dual_link_sync;
  logic [11:0] pin_out_r;
  logic [11:0] pin_oe_r;

  gapm_sync #(.WIDTH(12)) u_pin_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pin_in_i),
    .sync_o(pin_in_sync)
  );
  gapm_sync #(.WIDTH(1)) u_link_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(dual_link_i),
    .sync_o(dual_link_sync)
  );

  wire wr_func = reg_wr_i && (reg_addr_i == gapm_pkg::ADDR_FUNC_SEL);
  wire wr_dir = reg_wr_i && (reg_addr_i == gapm_pkg::ADDR_GPIO_DIR);
  wire wr_out = reg_wr_i && (reg_addr_i == gapm_pkg::ADDR_GPIO_OUT);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      func_sel_r <= gapm_pkg::FUNC_SEL_RST;
      gpio_dir_r <= gapm_pkg::GPIO_DIR_RST;
      gpio_out_r <= gapm_pkg::GPIO_OUT_RST;
    end else begin
      if (wr_func) begin
        func_sel_r <= reg_wdata_i[2:0];
      end
      if (wr_dir) begin
        gpio_dir_r <= reg_wdata_i[11:0];
      end
      if (wr_out) begin
        gpio_out_r <= reg_wdata_i[11:0];
      end
    end
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  wire [31:0] status_word = {29'h0, dual_link_sync, 2'h0};
  wire [31:0] rd_mux =
    (reg_addr_i == gapm_pkg::ADDR_FUNC_SEL) ? {29'h0, func_sel_r} :
    (reg_addr_i == gapm_pkg::ADDR_GPIO_DIR) ? {20'h0, gpio_dir_r} :
    (reg_addr_i == gapm_pkg::ADDR_GPIO_OUT) ? {20'h0, gpio_out_r} :
    (reg_addr_i == gapm_pkg::ADDR_PIN_IN) ? {20'h0, pin_in_sync} :
    (reg_addr_i == gapm_pkg::ADDR_STATUS) ? status_word : 32'h0;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= reg_rd_i ? rd_mux : 32'h0;
    end
  end
  assign reg_rdata_o = rdata_r;

  // ----------------------------------------
  // Pin mux
  // ----------------------------------------
  wire slave_en = func_sel_r[gapm_pkg::FSEL_SLAVE_AUDIO];
  wire master_en = func_sel_r[gapm_pkg::FSEL_MASTER_AUDIO];
  // Fast pins gated by dual link
  wire [11:0] fast_ok = dual_link_sync ? 12'hfff : ~gapm_pkg::FAST_PIN_MASK;
  wire [11:0] gp_out = gpio_out_r & gpio_dir_r & fast_ok;
  wire [11:0] gp_oe = gpio_dir_r & fast_ok;

  logic [11:0] aud_sel;
  logic [11:0] aud_val;
  always_comb begin
    aud_sel = 12'h000;
    aud_val = 12'h000;
    if (slave_en) begin
      // Slave word clock on pin seven
      aud_sel[gapm_pkg::PIN_REG7] = 1'b1;
      aud_val[gapm_pkg::PIN_REG7] = audio_i.slave_word_clock;
      // Slave bit clock on pin eight
      aud_sel[gapm_pkg::PIN_REG8] = 1'b1;
      aud_val[gapm_pkg::PIN_REG8] = audio_i.slave_bit_clock;
      aud_sel[gapm_pkg::PIN_REG6] = 1'b1;
      aud_val[gapm_pkg::PIN_REG6] = audio_i.data_a;
      aud_sel[gapm_pkg::PIN_REG5] = 1'b1;
      aud_val[gapm_pkg::PIN_REG5] = audio_i.data_b;
      aud_sel[gapm_pkg::PIN_GIO2] = 1'b1;
      aud_val[gapm_pkg::PIN_GIO2] = audio_i.data_c;
      aud_sel[gapm_pkg::PIN_GIO3] = 1'b1;
      aud_val[gapm_pkg::PIN_GIO3] = audio_i.data_d;
    end
    if (master_en) begin
      // Master word clock on pin one
      aud_sel[gapm_pkg::PIN_GIO1] = 1'b1;
      aud_val[gapm_pkg::PIN_GIO1] = audio_i.master_word_clock;
    end
  end

  // Registered outputs; audio clocks lag one core cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_r <= 12'h000;
      pin_oe_r <= 12'h000;
    end else begin
      pin_out_r <= (aud_sel & aud_val) | (~aud_sel & gp_out);
      pin_oe_r <= aud_sel | gp_oe;
    end
  end
  assign pin_out_o = pin_out_r;
  assign pin_oe_o = pin_oe_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_fast_single_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !dual_link_sync && !slave_en |=> (pin_oe_o & gapm_pkg::FAST_PIN_MASK) == 12'h000)
    else $error("fast pin driven in single link");
  a_slave_wc_pin: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    slave_en |=> pin_oe_o[gapm_pkg::PIN_REG7] && pin_out_o[gapm_pkg::PIN_REG7] ==
      $past(audio_i.slave_word_clock))
    else $error("slave word clock not on pin seven");
  a_slave_bclk_pin: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    slave_en |=> pin_oe_o[gapm_pkg::PIN_REG8] && pin_out_o[gapm_pkg::PIN_REG8] ==
      $past(audio_i.slave_bit_clock))
    else $error("slave bit clock not on pin eight");
  a_slave_data_d: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    slave_en |=> pin_out_o[gapm_pkg::PIN_GIO3] == $past(audio_i.data_d))
    else $error("data d not on pin three");
  a_master_wc_pin: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    master_en |=> pin_oe_o[gapm_pkg::PIN_GIO1] && pin_out_o[gapm_pkg::PIN_GIO1] ==
      $past(audio_i.master_word_clock))
    else $error("master word clock not on pin one");
  a_gpio_low_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    gpio_out_r == 12'h000 && func_sel_r == 3'h0 |=> pin_out_o == 12'h000)
    else $error("gpio not low by default");
  a_audio_override: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    slave_en && gpio_dir_r[gapm_pkg::PIN_REG6] == 1'b0 |=> pin_oe_o[gapm_pkg::PIN_REG6])
    else $error("gpio direction overrode audio");
  a_func_by_reg: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_func |=> func_sel_r == $past(reg_wdata_i[2:0]))
    else $error("function select not taken");
  a_reset_tristate: assert property (@(posedge core_clk_i)
    $rose(rst_n_i) |-> pin_oe_o == 12'h000)
    else $error("pins driven after reset");
  a_regonly_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !slave_en && gpio_dir_r[gapm_pkg::PIN_REG5] |=>
      pin_out_o[gapm_pkg::PIN_REG5] == $past(gpio_out_r[gapm_pkg::PIN_REG5]))
    else $error("register pin five not from register");
  a_slave_data_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    slave_en |=> pin_oe_o[gapm_pkg::PIN_REG6] && pin_out_o[gapm_pkg::PIN_REG6] ==
      $past(audio_i.data_a))
    else $error("data a not on pin six");
  a_slave_data_b: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    slave_en |=> pin_oe_o[gapm_pkg::PIN_REG5] && pin_out_o[gapm_pkg::PIN_REG5] ==
      $past(audio_i.data_b))
    else $error("data b not on pin five");
  a_slave_data_c: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    slave_en |=> pin_oe_o[gapm_pkg::PIN_GIO2] && pin_out_o[gapm_pkg::PIN_GIO2] ==
      $past(audio_i.data_c))
    else $error("data c not on pin two");
  a_fast_dual_gpio: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    dual_link_sync && gpio_dir_r[gapm_pkg::PIN_FAST2] |=> pin_oe_o[gapm_pkg::PIN_FAST2] &&
      pin_out_o[gapm_pkg::PIN_FAST2] == $past(gpio_out_r[gapm_pkg::PIN_FAST2]))
    else $error("fast pin two not usable in dual link");
  a_reset_low_out: assert property (@(posedge core_clk_i)
    $rose(rst_n_i) |-> pin_out_o == 12'h000)
    else $error("pins not low after reset");
  a_rdata_idle_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
  a_func_readback: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == gapm_pkg::ADDR_FUNC_SEL |=>
      reg_rdata_o == {29'h0, $past(func_sel_r)})
    else $error("function select readback wrong");
  a_gio1_gpio_path: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !master_en |=> pin_out_o[gapm_pkg::PIN_GIO1] ==
      $past(gpio_out_r[gapm_pkg::PIN_GIO1] & gpio_dir_r[gapm_pkg::PIN_GIO1]))
    else $error("pin one not from gpio registers");
  a_gio0_undriven: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !gpio_dir_r[gapm_pkg::PIN_GIO0] |=> !pin_oe_o[gapm_pkg::PIN_GIO0] && !pin_out_o[gapm_pkg::PIN_GIO0])
    else $error("pin zero driven as input");
endmodule
`default_nettype wire

// ### tb/gapm_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Pads with weak pull-down and loads
// ----------------------------------------
module gapm_pad_model (
  input wire logic [11:0] pin_out_i,
  input wire logic [11:0] pin_oe_i,
  output logic [11:0] pin_in_o
);
  // Undriven pad falls to the pull-down level
  assign pin_in_o = pin_out_i & pin_oe_i;
endmodule
`default_nettype wire

// ### tb/gapm_pin_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gapm_pin_mux_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic dual = 1'b0;
  gapm_pkg::gapm_audio_t aud = '0;
  logic [31:0] rdata;
  logic [11:0] pin_in, pin_out, pin_oe;
  logic [31:0] d;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  gapm_pin_mux i_gapm_pin_mux (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .dual_link_i(dual), .audio_i(aud), .pin_in_i(pin_in), .pin_out_o(pin_out),
    .pin_oe_o(pin_oe));
  gapm_pad_model i_gapm_pad_model (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .pin_in_o(pin_in));
  // ----------------------------------------
  // Bus tasks and compare
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Sync chains need a few edges beyond the one-cycle pin lag
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    #1 chk({20'h0, pin_oe}, 32'h0);
    chk({20'h0, pin_out}, 32'h0);
    rreg(gapm_pkg::ADDR_FUNC_SEL, d);
    chk(d, 32'h0);
    // Read data stands one cycle only
    @(posedge clk);
    #1 chk(rdata, 32'h0);
  endtask
  task automatic t_gpio();
    wreg(gapm_pkg::ADDR_GPIO_DIR, 32'hfff);
    wreg(gapm_pkg::ADDR_GPIO_OUT, 32'ha5a);
    settle();
    chk({20'h0, pin_oe}, 32'hf9f);
    chk({20'h0, pin_out & 12'hf9f}, 32'ha1a);
    @(posedge clk) dual <= 1'b1;
    settle();
    chk({20'h0, pin_oe}, 32'hfff);
    chk({20'h0, pin_out}, 32'ha5a);
    rreg(gapm_pkg::ADDR_PIN_IN, d);
    chk(d, 32'ha5a);
    rreg(gapm_pkg::ADDR_STATUS, d);
    chk(d & 32'h4, 32'h4);
    rreg(4'hf, d);
    chk(d, 32'h0);
  endtask
  task automatic t_slave();
    // Jitter cleaner is assumed off by software before this
    // software duty
    wreg(gapm_pkg::ADDR_GPIO_DIR, 32'h0);
    wreg(gapm_pkg::ADDR_GPIO_OUT, 32'h0);
    aud <= 7'h55;
    wreg(gapm_pkg::ADDR_FUNC_SEL, 32'h1);
    settle();
    chk({20'h0, pin_oe & 12'h78c}, 32'h78c);
    chk({20'h0, pin_out & 12'h78c}, 32'h304);
    wreg(gapm_pkg::ADDR_GPIO_DIR, 32'hfff);
    wreg(gapm_pkg::ADDR_GPIO_OUT, 32'hfff);
    aud <= 7'h2a;
    settle();
    chk({20'h0, pin_out & 12'h78c}, 32'h488);
  endtask
  task automatic t_master();
    wreg(gapm_pkg::ADDR_FUNC_SEL, 32'h6);
    rreg(gapm_pkg::ADDR_FUNC_SEL, d);
    chk(d, 32'h6);
    settle();
    chk({20'h0, pin_out & 12'h002}, 32'h0);
    @(posedge clk) aud <= 7'h01;
    settle();
    chk({20'h0, pin_out & 12'h002}, 32'h002);
    chk({20'h0, pin_out & 12'h78c}, 32'h78c);
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_gpio();
    t_slave();
    t_master();
    end_of_test();
  end
endmodule
`default_nettype wire
